// File: logic/artc_apb_regs.sv
// APB slave holding the software-visible registers
`timescale 1ns/10ps
module artc_apb_regs
  import artc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic filled_block_indicator,
  input wire logic [ARTC_ADDR_W-1:0] current_address,
  input wire logic [ARTC_IRQ_W-1:0] irq_event,
  output logic two_block,
  output logic continuous_transfer,
  output logic fetch_control,
  output logic [ARTC_COUNT_W-1:0] transfer_count,
  output logic [ARTC_ADDR_W-1:0] transfer_start_address,
  output logic start_written,
  output logic irq
);
  // ==========================================================================
  // Decode
  logic [ARTC_IRQ_W-1:0] status;
  logic [ARTC_IRQ_W-1:0] mask;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == ARTC_OFS_CONTROL;
  wire hit_count = paddr == ARTC_OFS_COUNT;
  wire hit_start = paddr == ARTC_OFS_START;
  wire hit_status = paddr == ARTC_OFS_STATUS;
  wire hit_mask = paddr == ARTC_OFS_MASK;
  wire hit_addr = paddr == ARTC_OFS_ADDR;
  wire mapped = hit_ctrl | hit_count | hit_start | hit_status | hit_mask | hit_addr;
  wire [ARTC_CTRL_W-1:0] ctrl_view = {two_block, continuous_transfer,
                                      filled_block_indicator, fetch_control};
  wire [ARTC_IRQ_W-1:0] next_status = irq_event | (status & ~(wr && hit_status ?
                                      pwdata[ARTC_IRQ_W-1:0] : '0));
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign start_written = wr && hit_start;
  assign irq = |(status & mask);
  // Upper control bits read as zero
  assign prdata = hit_ctrl ? {28'h0000000, ctrl_view} :
                  hit_count ? {24'h000000, transfer_count} :
                  hit_start ? {16'h0000, transfer_start_address} :
                  hit_status ? {30'h0, status} :
                  hit_mask ? {30'h0, mask} :
                  hit_addr ? {16'h0000, current_address} : 32'h00000000;
  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      two_block <= 1'b0;
      continuous_transfer <= 1'b0;
      fetch_control <= 1'b0;
      transfer_count <= ARTC_COUNT_RST;
      transfer_start_address <= ARTC_ADDR_RST;
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      if (wr && hit_ctrl) begin
        two_block <= pwdata[ARTC_BIT_TWO];
        continuous_transfer <= pwdata[ARTC_BIT_CONT];
        fetch_control <= pwdata[ARTC_BIT_FETCH];
      end
      if (wr && hit_count) begin
        transfer_count <= pwdata[ARTC_COUNT_W-1:0];
      end
      if (start_written) begin
        transfer_start_address <= {pwdata[ARTC_ADDR_W-1:1], 1'b0};
      end
      if (wr && hit_mask) begin
        mask <= pwdata[ARTC_IRQ_W-1:0];
      end
    end
  end
endmodule : artc_apb_regs

// File: logic/artc_mem_port.sv
// Memory write port: holds one result word until memory accepts it
`timescale 1ns/10ps
module artc_mem_port
  import artc_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic load,
  input wire logic [ARTC_ADDR_W-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_data,
  output logic busy,
  output logic mem_wr_valid,
  output logic [ARTC_ADDR_W-1:0] mem_wr_addr,
  output logic [DATA_W-1:0] mem_wr_data,
  input wire logic mem_wr_ready
);
  // ==========================================================================
  // Holding register
  wire accepted = mem_wr_valid && mem_wr_ready;
  assign busy = mem_wr_valid && !mem_wr_ready;
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= ARTC_ADDR_RST;
      mem_wr_data <= '0;
    end else if (load) begin
      mem_wr_valid <= 1'b1;
      mem_wr_addr <= load_addr;
      mem_wr_data <= load_data;
    end else if (accepted) begin
      mem_wr_valid <= 1'b0;
    end
  end
endmodule : artc_mem_port

// File: logic/artc_pkg.sv
// Package: register map, field positions and constants of the result transfer controller
package artc_pkg;
  // ==========================================================================
  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] ARTC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] ARTC_OFS_COUNT = 8'h04;
  localparam logic [7:0] ARTC_OFS_START = 8'h08;
  localparam logic [7:0] ARTC_OFS_STATUS = 8'h0c;
  localparam logic [7:0] ARTC_OFS_MASK = 8'h10;
  localparam logic [7:0] ARTC_OFS_ADDR = 8'h14;
  // ==========================================================================
  // Control register fields
  localparam int ARTC_BIT_FETCH = 0;
  localparam int ARTC_BIT_FILLED = 1;
  localparam int ARTC_BIT_CONT = 2;
  localparam int ARTC_BIT_TWO = 3;
  localparam int ARTC_CTRL_W = 4;
  // ==========================================================================
  // Interrupt status bits
  localparam int ARTC_IRQ_BLOCK = 0;
  localparam int ARTC_IRQ_DONE = 1;
  localparam int ARTC_IRQ_W = 2;
  // ==========================================================================
  // Widths, reset values and address step
  localparam int ARTC_COUNT_W = 8;
  localparam int ARTC_ADDR_W = 16;
  localparam logic [15:0] ARTC_ADDR_STEP = 16'h0002;
  localparam logic [7:0] ARTC_COUNT_RST = 8'h00;
  localparam logic [15:0] ARTC_ADDR_RST = 16'h0000;
  // ==========================================================================
  // Engine states
  typedef enum logic [2:0] {
    ARTC_IDLE = 3'b001,
    ARTC_WAIT = 3'b010,
    ARTC_WRITE = 3'b100
  } artc_state_t;
endpackage : artc_pkg

// File: logic/artc_top.sv
// Top: conversion result transfer controller with APB registers
//
// Functional notes
// - Control register bits 7 to 4 read as zero and do nothing.
// - Without continuous mode, transfer stops after one block, or two in two-block mode.
// - In continuous mode transfer runs until continuous is cleared or the count is written to zero; a start rewrite restarts it.
// - In two-block mode the filled-block bit is 1 for block one and 0 for block two.
// - The filled-block bit means something only after the first block flag, in two-block mode.
// - The count register sets transfers per block; zero disables the controller.
// - The first transfer goes to the start address.
// - Transfers begin only after the start address register is written.
// - Start address bit 0 always reads zero.
// - While active, the completion flag rises per block, not per conversion.
`timescale 1ns/10ps
module artc_top
  import artc_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result_data,
  output logic conversion_done_flag,
  input wire logic conversion_done_clear,
  output logic mem_wr_valid,
  output logic [ARTC_ADDR_W-1:0] mem_wr_addr,
  output logic [DATA_W-1:0] mem_wr_data,
  input wire logic mem_wr_ready,
  output logic active,
  output logic irq
);
  // ==========================================================================
  // Declarations
  artc_state_t state;
  artc_state_t next_state;
  logic two_block;
  logic continuous_transfer;
  logic fetch_control;
  logic [ARTC_COUNT_W-1:0] transfer_count;
  logic [ARTC_ADDR_W-1:0] transfer_start_address;
  logic start_written;
  logic [ARTC_ADDR_W-1:0] cur_addr;
  logic [ARTC_COUNT_W-1:0] xfer_left;
  logic second_block;
  logic filled_block_indicator;
  logic [DATA_W-1:0] held_result;
  logic port_busy;
  logic load;
  logic block_end;
  logic session_end;
  logic [ARTC_IRQ_W-1:0] irq_event;
  // ==========================================================================
  // Registers
  artc_apb_regs u_regs (
    .mclk(mclk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .filled_block_indicator(filled_block_indicator),
    .current_address(cur_addr),
    .irq_event(irq_event),
    .two_block(two_block),
    .continuous_transfer(continuous_transfer),
    .fetch_control(fetch_control),
    .transfer_count(transfer_count),
    .transfer_start_address(transfer_start_address),
    .start_written(start_written),
    .irq(irq)
  );
  // ==========================================================================
  // Memory port
  artc_mem_port #(
    .DATA_W(DATA_W)
  ) u_port (
    .mclk(mclk),
    .reset(reset),
    .load(load),
    .load_addr(cur_addr),
    .load_data(held_result),
    .busy(port_busy),
    .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data),
    .mem_wr_ready(mem_wr_ready)
  );
  // ==========================================================================
  // Control decode
  // A zero count disables the controller outright
  wire enabled = transfer_count != ARTC_COUNT_RST;
  wire [ARTC_COUNT_W-1:0] one = ARTC_COUNT_W'(1);
  assign active = state != ARTC_IDLE;
  // Write issued only once the previous word has left the port
  assign load = state == ARTC_WRITE && !port_busy;
  assign block_end = load && xfer_left == one;
  // One-shot ends after one block, or after the second in two-block mode
  assign session_end = block_end && !continuous_transfer && (!two_block || second_block);
  assign irq_event[ARTC_IRQ_BLOCK] = block_end;
  assign irq_event[ARTC_IRQ_DONE] = session_end;
  // Stop conditions: disabled count, or two-block cleared with continuous off while block two is pending
  wire halt = !enabled || (state != ARTC_IDLE && !continuous_transfer && !two_block
                           && second_block);
  // ==========================================================================
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ARTC_IDLE: begin
        // Only a start address write arms the engine
        if (start_written && enabled) begin
          next_state = ARTC_WAIT;
        end
      end
      ARTC_WAIT: begin
        if (start_written) begin
          next_state = enabled ? ARTC_WAIT : ARTC_IDLE;
        end else if (halt) begin
          next_state = ARTC_IDLE;
        end else if (result_valid) begin
          next_state = ARTC_WRITE;
        end
      end
      ARTC_WRITE: begin
        if (start_written) begin
          // A new start address restarts the engine, as it does while waiting
          next_state = enabled ? ARTC_WAIT : ARTC_IDLE;
        end else if (load) begin
          next_state = session_end ? ARTC_IDLE : ARTC_WAIT;
        end
      end
      default: begin
        next_state = ARTC_IDLE;
      end
    endcase
  end
  // ==========================================================================
  // Engine
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ARTC_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Clearing continuous mid-run finishes the block in progress, and block two if pending, then stops; the
  // halt term above stops at the next wait when two-block is cleared during block two.
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_addr <= ARTC_ADDR_RST;
      xfer_left <= ARTC_COUNT_RST;
      second_block <= 1'b0;
      held_result <= '0;
    end else if (start_written) begin
      cur_addr <= {pwdata[ARTC_ADDR_W-1:1], 1'b0};
      xfer_left <= transfer_count;
      second_block <= 1'b0;
    end else begin
      if (state == ARTC_WAIT && result_valid) begin
        held_result <= result_data;
      end
      if (load) begin
        if (block_end) begin
          xfer_left <= transfer_count;
          // Block two follows block one; wrap to the start afterwards
          if (two_block && !second_block) begin
            second_block <= 1'b1;
            cur_addr <= cur_addr + ARTC_ADDR_STEP;
          end else begin
            second_block <= 1'b0;
            cur_addr <= transfer_start_address;
          end
        end else begin
          xfer_left <= xfer_left - one;
          cur_addr <= cur_addr + ARTC_ADDR_STEP;
        end
      end
    end
  end
  // ==========================================================================
  // Completion flag and filled-block indicator
  always_ff @(posedge mclk) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
      filled_block_indicator <= 1'b0;
    end else begin
      // Set per block, and set wins over a clear in the same cycle
      if (block_end) begin
        conversion_done_flag <= 1'b1;
      end else if (conversion_done_clear) begin
        conversion_done_flag <= 1'b0;
      end
      // Meaningful only in two-block mode after the first block flag
      if (start_written) begin
        filled_block_indicator <= 1'b0;
      end else if (block_end && two_block) begin
        filled_block_indicator <= !second_block;
      end
    end
  end
endmodule : artc_top

// File: verification/artc_mem_model.sv
// Memory model: takes result words, promptly or after a stall
`timescale 1ns/10ps
module artc_mem_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_wr_valid,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  output logic mem_wr_ready
);
  // ==========================================================================
  // Accept logic
  logic [1:0] wait_cnt;
  logic [15:0] last_addr;
  logic [15:0] last_data;
  int n_wr;
  // Slow mode holds ready low three cycles, so the held word must stay put
  assign mem_wr_ready = mem_wr_valid && (!slow || wait_cnt == 2'h3);
  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_cnt <= 2'h0;
      n_wr <= 0;
    end else if (mem_wr_ready) begin
      wait_cnt <= 2'h0;
      n_wr <= n_wr + 1;
      last_addr <= mem_wr_addr;
      last_data <= mem_wr_data;
    end else if (mem_wr_valid) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : artc_mem_model

// File: verification/artc_top_asserts.sv
// Checker: port-level properties of the transfer controller
`timescale 1ns/10ps
module artc_top_asserts
  import artc_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic conversion_done_flag,
  input wire logic conversion_done_clear,
  input wire logic mem_wr_valid,
  input wire logic [ARTC_ADDR_W-1:0] mem_wr_addr,
  input wire logic [DATA_W-1:0] mem_wr_data,
  input wire logic mem_wr_ready,
  input wire logic active,
  input wire logic irq
);
  // ==========================================================================
  // Helpers
  logic armed;
  wire rd_acc = psel && penable && !pwrite;
  wire start_wr = psel && penable && pwrite && paddr == ARTC_OFS_START;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  always_ff @(posedge mclk) begin
    if (reset) armed <= 1'b0;
    else if (start_wr) armed <= 1'b1;
  end
  // ==========================================================================
  // Properties
  sequence s_take;
    result_valid && active && !mem_wr_valid ##1 !mem_wr_valid;
  endsequence
  property p_rsv; rd_acc && paddr == ARTC_OFS_CONTROL |-> prdata[31:4] == 28'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("control upper bits not zero");
  property p_sa0; rd_acc && paddr == ARTC_OFS_START |-> !prdata[0]; endproperty
  a_sa0: assert property (p_sa0) else $error("start address bit 0 set");
  property p_arm; !armed |-> !active && !mem_wr_valid; endproperty
  a_arm: assert property (p_arm) else $error("engine ran before start write");
  property p_lat; s_take |=> mem_wr_valid && mem_wr_data == $past(result_data, 2); endproperty
  a_lat: assert property (p_lat) else $error("result word not written");
  property p_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("held word changed");
  property p_flag; $rose(conversion_done_flag) |-> $rose(mem_wr_valid); endproperty
  a_flag: assert property (p_flag) else $error("flag rose without a word");
  property p_clr; conversion_done_clear |=> !conversion_done_flag || $rose(mem_wr_valid); endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_err; psel && penable && paddr > ARTC_OFS_ADDR |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule : artc_top_asserts
bind artc_top artc_top_asserts #(.DATA_W(DATA_W)) u_asserts (
  .mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .result_valid, .result_data, .conversion_done_flag, .conversion_done_clear,
  .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready, .active, .irq
);

// File: verification/testbench.sv
// Testbench: register, one-shot, two-block and continuous scenarios
`timescale 1ns/10ps
module testbench;
  import artc_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, active, irq, mem_wr_valid, mem_wr_ready, slow = 1'b0;
  logic result_valid = 1'b0, conversion_done_flag, conversion_done_clear = 1'b0;
  logic [15:0] result_data = 16'h0, mem_wr_addr, mem_wr_data;
  int errors = 0, n_compared = 0, cycles = 0;
  always #2 mclk = ~mclk;
  artc_top #(.DATA_W(16)) DUT (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .result_valid, .result_data, .conversion_done_flag,
    .conversion_done_clear, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready,
    .active, .irq);
  artc_mem_model u_mem (.mclk, .reset, .slow, .mem_wr_valid, .mem_wr_addr, .mem_wr_data,
    .mem_wr_ready);
  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge mclk);
    end
    if (k == 50) chk("pready", pready, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the edge's register updates land before anything is sampled
    #1;
  endtask : apb
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rdc
  task automatic clr();
    @(posedge mclk);
    conversion_done_clear <= 1'b1;
    @(posedge mclk);
    conversion_done_clear <= 1'b0;
    #1;
    chk("flag cleared", conversion_done_flag, 32'h0);
  endtask : clr
  task automatic send(input logic [15:0] d, input logic wr, input logic [15:0] ea);
    int n0, k;
    n0 = u_mem.n_wr;
    k = 0;
    @(posedge mclk);
    result_valid <= 1'b1;
    result_data <= d;
    @(posedge mclk);
    result_valid <= 1'b0;
    while (u_mem.n_wr == n0 && k < 12) begin
      k++;
      @(posedge mclk);
    end
    #1;
    chk("write count", u_mem.n_wr - n0, {31'h0, wr});
    if (wr) chk("mem addr", u_mem.last_addr, ea);
    if (wr) chk("mem data", u_mem.last_data, d);
  endtask : send
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rdc("control", ARTC_OFS_CONTROL, 32'h0);
    rdc("count", ARTC_OFS_COUNT, 32'h0);
    apb(1'b1, ARTC_OFS_CONTROL, 32'h000000fe);
    rdc("control rsv", ARTC_OFS_CONTROL, 32'h0000000c);
    apb(1'b1, ARTC_OFS_CONTROL, 32'h0);
    apb(1'b1, ARTC_OFS_START, 32'h0000ffff);
    rdc("start bit0", ARTC_OFS_START, 32'h0000fffe);
    send(16'h0011, 1'b0, 16'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("pslverr", err, 32'h1);
    chk("pready idle", pready, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_one();
    apb(1'b1, ARTC_OFS_COUNT, 32'h3);
    apb(1'b1, ARTC_OFS_MASK, 32'h1);
    send(16'h0021, 1'b0, 16'h0);
    apb(1'b1, ARTC_OFS_START, 32'h0100);
    send(16'h0031, 1'b1, 16'h0100);
    send(16'h0032, 1'b1, 16'h0102);
    chk("flag early", conversion_done_flag, 32'h0);
    send(16'h0033, 1'b1, 16'h0104);
    chk("flag", conversion_done_flag, 32'h1);
    chk("irq", irq, 32'h1);
    rdc("status", ARTC_OFS_STATUS, 32'h3);
    apb(1'b1, ARTC_OFS_MASK, 32'h0);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, ARTC_OFS_STATUS, 32'h3);
    apb(1'b1, ARTC_OFS_MASK, 32'h3);
    chk("irq cleared", irq, 32'h0);
    send(16'h0034, 1'b0, 16'h0);
    chk("active", active, 32'h0);
    $display("test one-shot done");
  endtask : t_one
  task automatic t_two();
    clr();
    slow <= 1'b1;
    apb(1'b1, ARTC_OFS_CONTROL, 32'h8);
    apb(1'b1, ARTC_OFS_COUNT, 32'h2);
    apb(1'b1, ARTC_OFS_START, 32'h0200);
    send(16'h0041, 1'b1, 16'h0200);
    send(16'h0042, 1'b1, 16'h0202);
    chk("flag block one", conversion_done_flag, 32'h1);
    rdc("filled one", ARTC_OFS_CONTROL, 32'h0000000a);
    clr();
    send(16'h0043, 1'b1, 16'h0204);
    send(16'h0044, 1'b1, 16'h0206);
    rdc("filled two", ARTC_OFS_CONTROL, 32'h00000008);
    rdc("cur addr", ARTC_OFS_ADDR, 32'h00000200);
    send(16'h0045, 1'b0, 16'h0);
    $display("test two-block done");
  endtask : t_two
  task automatic t_cont();
    slow <= 1'b0;
    apb(1'b1, ARTC_OFS_CONTROL, 32'h4);
    apb(1'b1, ARTC_OFS_START, 32'h0300);
    for (int i = 0; i < 5; i++) send(16'h0050 + 16'(i), 1'b1, 16'h0300 + 16'(2 * (i % 2)));
    apb(1'b1, ARTC_OFS_START, 32'h0400);
    send(16'h0056, 1'b1, 16'h0400);
    apb(1'b1, ARTC_OFS_CONTROL, 32'h0);
    send(16'h0057, 1'b1, 16'h0402);
    send(16'h0058, 1'b0, 16'h0);
    apb(1'b1, ARTC_OFS_CONTROL, 32'h4);
    apb(1'b1, ARTC_OFS_START, 32'h0500);
    chk("armed", active, 32'h1);
    apb(1'b1, ARTC_OFS_COUNT, 32'h0);
    // The halt takes effect one edge after the count write lands
    @(posedge mclk);
    #1;
    chk("count zero stops", active, 32'h0);
    $display("test continuous done");
  endtask : t_cont
  // ==========================================================================
  // Run control
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_one();
    t_two();
    t_cont();
    report_and_stop();
  end
endmodule : testbench
